// File: design/epbc_core.sv
// epbc_core: per-function bar windows, bar hit decode to local addresses,
// legacy/msi/msi-x settings and gating, behind an apb register port.
// assumes requests and interrupt sources come from logic on clk.
`timescale 1ns/1ps

module epbc_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // received request and its decode
  input wire logic req_valid,
  input wire epbc_pkg::epbc_req_s req,
  output logic hit_valid,
  output epbc_pkg::epbc_hit_s hit,
  // interrupt sources
  input wire logic leg_req,
  input wire logic leg_assert,
  input wire logic msi_req,
  input wire logic msix_req,
  input wire epbc_pkg::epbc_irq_s irq,
  // interrupt results
  output logic [3:0] legacy_int,
  output logic msi_send,
  output logic msix_send,
  output logic irq_drop
);

  epbc_pkg::epbc_bar_cfg_s bar_cfg_r [epbc_pkg::NUM_ENTRIES][epbc_pkg::NUM_BARS];
  logic [31:0] bar_base_r [epbc_pkg::NUM_ENTRIES][epbc_pkg::NUM_BARS];
  logic [31:0] loc_base_r [epbc_pkg::NUM_ENTRIES][epbc_pkg::NUM_BARS];
  epbc_pkg::epbc_irq_ctl_s irq_ctl_r [epbc_pkg::NUM_ENTRIES];
  logic [28:0] tbl_off_r [epbc_pkg::NUM_ENTRIES];
  logic [28:0] pba_off_r [epbc_pkg::NUM_ENTRIES];
  logic [31:0] msi_mask_r [epbc_pkg::NUM_ENTRIES];
  logic [3:0] num_func_r [epbc_pkg::NUM_LINKS];
  logic [15:0] hit_count_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic hit_valid_r;
  epbc_pkg::epbc_hit_s hit_r;
  logic [3:0] legacy_int_r;
  logic msi_send_r;
  logic msix_send_r;
  logic irq_drop_r;

  // window mask below the size exponent
  function automatic logic [63:0] win_mask(input logic [5:0] s);
    win_mask = (64'h1 << s) - 64'h1;
  endfunction : win_mask

  // bar is legal for its type and size and position
  function automatic logic bar_legal(input epbc_pkg::epbc_bar_cfg_s c, input int n);
    logic ok;
    ok = 1'b0;
    if (c.io)
      ok = !c.is64 && !c.prefetch && c.size_log2 >= epbc_pkg::SIZE_IO_MIN
           && c.size_log2 <= epbc_pkg::SIZE_IO_MAX;
    else if (c.is64)
      ok = (n < epbc_pkg::NUM_BARS - 1) && c.size_log2 >= epbc_pkg::SIZE_MEM64_MIN;
    else
      ok = c.size_log2 >= epbc_pkg::SIZE_MEM32_MIN && c.size_log2 <= epbc_pkg::SIZE_MEM32_MAX;
    bar_legal = c.en && ok;
  endfunction : bar_legal

  // page index from link and function
  function automatic logic [3:0] page(input logic link, input logic [2:0] func);
    page = {link, func};
  endfunction : page

  // apb decode of the current access
  logic [3:0] a_pg;
  logic [5:0] a_word;
  logic a_map;
  logic a_take;
  assign a_pg = {paddr[epbc_pkg::ADDR_LINK_BIT], paddr[epbc_pkg::ADDR_FUNC_LSB +: 3]};
  assign a_word = paddr[epbc_pkg::ADDR_WORD_LSB +: 6];
  assign a_map = a_word <= epbc_pkg::REG_STATUS;
  assign a_take = psel && penable && pready_r;

  // read data for the addressed word
  logic [31:0] rd_data;
  logic [2:0] rd_bar;
  always_comb
  begin
    rd_data = 32'h0;
    rd_bar = 3'h0;
    if (a_word < epbc_pkg::REG_BAR_BASE)
    begin
      rd_bar = a_word[2:0];
      rd_data[epbc_pkg::CFG_EN_BIT] = bar_cfg_r[a_pg][rd_bar].en;
      rd_data[epbc_pkg::CFG_IO_BIT] = bar_cfg_r[a_pg][rd_bar].io;
      rd_data[epbc_pkg::CFG_B64_BIT] = bar_cfg_r[a_pg][rd_bar].is64;
      rd_data[epbc_pkg::CFG_PF_BIT] = bar_cfg_r[a_pg][rd_bar].prefetch;
      rd_data[epbc_pkg::CFG_SIZE_LSB +: 6] = bar_cfg_r[a_pg][rd_bar].size_log2;
      rd_data[epbc_pkg::CFG_LEGAL_BIT] = bar_legal(bar_cfg_r[a_pg][rd_bar], int'(rd_bar));
    end
    else if (a_word < epbc_pkg::REG_LOC_BASE)
      rd_data = bar_base_r[a_pg][3'(a_word - epbc_pkg::REG_BAR_BASE)];
    else if (a_word < epbc_pkg::REG_IRQ_CTL)
      rd_data = loc_base_r[a_pg][3'(a_word - epbc_pkg::REG_LOC_BASE)];
    else if (a_word == epbc_pkg::REG_IRQ_CTL)
    begin
      rd_data[epbc_pkg::IRQ_LEG_OFF_BIT] = irq_ctl_r[a_pg].leg_off;
      rd_data[epbc_pkg::IRQ_PIN_LSB +: 2] = irq_ctl_r[a_pg].pin;
      rd_data[epbc_pkg::IRQ_MSI_OFF_BIT] = irq_ctl_r[a_pg].msi_off;
      rd_data[epbc_pkg::IRQ_MSI_MMC_LSB +: 3] = irq_ctl_r[a_pg].msi_mmc;
      rd_data[epbc_pkg::IRQ_MSI_MASKCAP_BIT] = irq_ctl_r[a_pg].msi_maskcap;
    end
    else if (a_word == epbc_pkg::REG_MSIX_CTL)
    begin
      rd_data[epbc_pkg::MSIX_OFF_BIT] = irq_ctl_r[a_pg].msix_off;
      rd_data[epbc_pkg::MSIX_CNT_LSB +: 11] = irq_ctl_r[a_pg].msix_cnt_m1;
      rd_data[epbc_pkg::MSIX_TBIR_LSB +: 3] = irq_ctl_r[a_pg].tbl_bir;
      rd_data[epbc_pkg::MSIX_PBIR_LSB +: 3] = irq_ctl_r[a_pg].pba_bir;
      // config space address of the table bar
      rd_data[epbc_pkg::MSIX_TCFG_LSB +: 8] = epbc_pkg::CFG_BAR_BLOCK
        + {3'h0, irq_ctl_r[a_pg].tbl_bir, 2'h0};
    end
    else if (a_word == epbc_pkg::REG_MSIX_TBL)
      rd_data = {tbl_off_r[a_pg], 3'h0};
    else if (a_word == epbc_pkg::REG_MSIX_PBA)
      rd_data = {pba_off_r[a_pg], 3'h0};
    else if (a_word == epbc_pkg::REG_MSI_MASK)
      rd_data = msi_mask_r[a_pg];
    else if (a_word == epbc_pkg::REG_NUM_FUNC)
      rd_data = {28'h0, num_func_r[a_pg[3]]};
    else if (a_word == epbc_pkg::REG_STATUS)
      rd_data = {13'h0, hit_r.bar, hit_count_r};
  end

  // apb handshake: one wait-free access phase after each setup
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end
    else
    begin
      pready_r <= psel && !penable && !pready_r;
      if (psel && !penable)
      begin
        pslverr_r <= !a_map;
        prdata_r <= (!pwrite && a_map) ? rd_data : 32'h0;
      end
    end
  end

  // configuration writes, all bars reset to disabled
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int e = 0; e < epbc_pkg::NUM_ENTRIES; e++)
      begin
        for (int b = 0; b < epbc_pkg::NUM_BARS; b++)
        begin
          bar_cfg_r[e][b] <= '0;
          bar_base_r[e][b] <= 32'h0;
          loc_base_r[e][b] <= 32'h0;
        end
        irq_ctl_r[e] <= '0;
        tbl_off_r[e] <= 29'h0;
        pba_off_r[e] <= 29'h0;
        msi_mask_r[e] <= 32'h0;
      end
      for (int l = 0; l < epbc_pkg::NUM_LINKS; l++)
        num_func_r[l] <= epbc_pkg::NUM_FUNC_RST;
    end
    else if (a_take && pwrite && a_map)
    begin
      if (a_word < epbc_pkg::REG_BAR_BASE)
      begin
        bar_cfg_r[a_pg][a_word[2:0]].en <= pwdata[epbc_pkg::CFG_EN_BIT];
        bar_cfg_r[a_pg][a_word[2:0]].io <= pwdata[epbc_pkg::CFG_IO_BIT];
        bar_cfg_r[a_pg][a_word[2:0]].is64 <= pwdata[epbc_pkg::CFG_B64_BIT]
          && !pwdata[epbc_pkg::CFG_IO_BIT];
        bar_cfg_r[a_pg][a_word[2:0]].prefetch <= pwdata[epbc_pkg::CFG_PF_BIT]
          && !pwdata[epbc_pkg::CFG_IO_BIT];
        bar_cfg_r[a_pg][a_word[2:0]].size_log2 <= pwdata[epbc_pkg::CFG_SIZE_LSB +: 6];
      end
      else if (a_word < epbc_pkg::REG_LOC_BASE)
        bar_base_r[a_pg][3'(a_word - epbc_pkg::REG_BAR_BASE)] <= pwdata;
      else if (a_word < epbc_pkg::REG_IRQ_CTL)
        loc_base_r[a_pg][3'(a_word - epbc_pkg::REG_LOC_BASE)] <= pwdata;
      else if (a_word == epbc_pkg::REG_IRQ_CTL)
      begin
        irq_ctl_r[a_pg].leg_off <= pwdata[epbc_pkg::IRQ_LEG_OFF_BIT];
        irq_ctl_r[a_pg].pin <= pwdata[epbc_pkg::IRQ_PIN_LSB +: 2];
        irq_ctl_r[a_pg].msi_off <= pwdata[epbc_pkg::IRQ_MSI_OFF_BIT];
        if (pwdata[epbc_pkg::IRQ_MSI_MMC_LSB +: 3] <= epbc_pkg::MSI_MMC_MAX)
          irq_ctl_r[a_pg].msi_mmc <= pwdata[epbc_pkg::IRQ_MSI_MMC_LSB +: 3];
        irq_ctl_r[a_pg].msi_maskcap <= pwdata[epbc_pkg::IRQ_MSI_MASKCAP_BIT];
      end
      else if (a_word == epbc_pkg::REG_MSIX_CTL)
      begin
        irq_ctl_r[a_pg].msix_off <= pwdata[epbc_pkg::MSIX_OFF_BIT];
        irq_ctl_r[a_pg].msix_cnt_m1 <= pwdata[epbc_pkg::MSIX_CNT_LSB +: 11];
        if (pwdata[epbc_pkg::MSIX_TBIR_LSB +: 3] <= epbc_pkg::BIR_MAX)
          irq_ctl_r[a_pg].tbl_bir <= pwdata[epbc_pkg::MSIX_TBIR_LSB +: 3];
        if (pwdata[epbc_pkg::MSIX_PBIR_LSB +: 3] <= epbc_pkg::BIR_MAX)
          irq_ctl_r[a_pg].pba_bir <= pwdata[epbc_pkg::MSIX_PBIR_LSB +: 3];
      end
      else if (a_word == epbc_pkg::REG_MSIX_TBL)
        tbl_off_r[a_pg] <= pwdata[31:epbc_pkg::OFFSET_SHIFT];
      else if (a_word == epbc_pkg::REG_MSIX_PBA)
        pba_off_r[a_pg] <= pwdata[31:epbc_pkg::OFFSET_SHIFT];
      else if (a_word == epbc_pkg::REG_MSI_MASK)
        msi_mask_r[a_pg] <= pwdata;
      else if (a_word == epbc_pkg::REG_NUM_FUNC)
      begin
        if (pwdata[3:0] >= epbc_pkg::NUM_FUNC_RST && pwdata[3:0] <= epbc_pkg::NUM_FUNC_MAX)
          num_func_r[a_pg[3]] <= pwdata[3:0];
      end
    end
  end

  // bar decode for the requesting function, lowest bar wins
  logic [3:0] r_pg;
  logic [5:0] claim;
  logic any_hit;
  logic [2:0] hb;
  logic [63:0] hmask;
  logic [63:0] hoff;
  epbc_pkg::epbc_region_e rgn;
  assign r_pg = page(req.link, req.func);
  always_comb
  begin
    claim = 6'h0;
    for (int n = 0; n < epbc_pkg::NUM_BARS; n++)
    begin
      logic [63:0] base;
      logic [63:0] m;
      logic upper;
      base = {32'h0, bar_base_r[r_pg][n]};
      m = win_mask(bar_cfg_r[r_pg][n].size_log2);
      upper = (n > 0) && bar_cfg_r[r_pg][(n + 5) % 6].en && bar_cfg_r[r_pg][(n + 5) % 6].is64;
      if (bar_cfg_r[r_pg][n].is64 && n < epbc_pkg::NUM_BARS - 1)
        base[63:32] = bar_base_r[r_pg][(n + 1) % epbc_pkg::NUM_BARS];
      claim[n] = bar_legal(bar_cfg_r[r_pg][n], n) && !upper
        && (bar_cfg_r[r_pg][n].io == req.io)
        && ((req.addr & ~m) == (base & ~m));
    end
  end

  // winning bar, offset and msi-x region
  always_comb
  begin
    any_hit = 1'b0;
    hb = 3'h0;
    for (int n = epbc_pkg::NUM_BARS - 1; n >= 0; n--)
    begin
      if (claim[n])
      begin
        any_hit = 1'b1;
        hb = 3'(n);
      end
    end
    hmask = win_mask(bar_cfg_r[r_pg][hb].size_log2);
    hoff = req.addr & hmask;
    rgn = epbc_pkg::EPBC_RGN_NONE;
    if (!irq_ctl_r[r_pg].msix_off && !req.io)
    begin
      if (hb == irq_ctl_r[r_pg].tbl_bir
          && hoff >= {32'h0, tbl_off_r[r_pg], 3'h0}
          && hoff < {32'h0, tbl_off_r[r_pg], 3'h0}
            + ({53'h0, irq_ctl_r[r_pg].msix_cnt_m1} + 64'h1 << epbc_pkg::MSIX_ENTRY_SHIFT))
        rgn = epbc_pkg::EPBC_RGN_TABLE;
      else if (hb == irq_ctl_r[r_pg].pba_bir
          && hoff >= {32'h0, pba_off_r[r_pg], 3'h0}
          && hoff < {32'h0, pba_off_r[r_pg], 3'h0}
            + ((({53'h0, irq_ctl_r[r_pg].msix_cnt_m1} >> 6) + 64'h1) << 3))
        rgn = epbc_pkg::EPBC_RGN_PBA;
    end
  end

  // registered decode answer one cycle after each request
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hit_valid_r <= 1'b0;
      hit_r <= '0;
      hit_count_r <= 16'h0;
    end
    else
    begin
      hit_valid_r <= req_valid;
      if (req_valid)
      begin
        hit_r.miss <= !any_hit || ({1'b0, req.func} >= num_func_r[req.link]);
        hit_r.bar <= hb;
        hit_r.local_addr <= loc_base_r[r_pg][hb] + hoff[31:0];
        hit_r.prefetch <= any_hit && bar_cfg_r[r_pg][hb].prefetch;
        hit_r.region <= rgn;
        if (any_hit && {1'b0, req.func} < num_func_r[req.link])
          hit_count_r <= hit_count_r + 16'h1;
      end
    end
  end

  // interrupt gating for the selected function
  logic [3:0] i_pg;
  logic i_func_ok;
  logic msi_ok;
  logic msix_ok;
  assign i_pg = page(irq.link, irq.func);
  assign i_func_ok = {1'b0, irq.func} < num_func_r[irq.link];
  assign msi_ok = i_func_ok && !irq_ctl_r[i_pg].msi_off
    && (irq.vec < (11'h1 << irq_ctl_r[i_pg].msi_mmc))
    && !(irq_ctl_r[i_pg].msi_maskcap && msi_mask_r[i_pg][irq.vec[4:0]]);
  assign msix_ok = i_func_ok && !irq_ctl_r[i_pg].msix_off
    && (irq.vec <= irq_ctl_r[i_pg].msix_cnt_m1);

  // legacy wire level and message pulses
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      legacy_int_r <= 4'h0;
      msi_send_r <= 1'b0;
      msix_send_r <= 1'b0;
      irq_drop_r <= 1'b0;
    end
    else
    begin
      if (leg_req && i_func_ok)
      begin
        if (irq_ctl_r[i_pg].leg_off)
          legacy_int_r <= 4'h0;
        else
          legacy_int_r <= leg_assert ? (4'h1 << irq_ctl_r[i_pg].pin) : 4'h0;
      end
      msi_send_r <= msi_req && msi_ok;
      msix_send_r <= msix_req && msix_ok;
      irq_drop_r <= (msi_req && !msi_ok) || (msix_req && !msix_ok);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign hit_valid = hit_valid_r;
  assign hit = hit_r;
  assign legacy_int = legacy_int_r;
  assign msi_send = msi_send_r;
  assign msix_send = msix_send_r;
  assign irq_drop = irq_drop_r;

  // apb setup followed by a one-cycle ready
  sequence s_setup;
    psel && !penable && !pready;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence

  a_apb_ready_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    s_setup |=> s_access ##1 !pready) else $error("apb ready not a single pulse");
  a_unmapped_err: assert property (@(posedge clk) disable iff (!rst_n)
    s_setup ##0 (paddr[7:2] > epbc_pkg::REG_STATUS) |=> pslverr) else $error("no error");
  a_miss_count: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && !any_hit |=> hit_valid && hit.miss && $stable(hit_count_r))
    else $error("missed request counted");
  a_func_limit: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && ({1'b0, req.func} >= num_func_r[req.link]) |=> hit.miss)
    else $error("disabled function claimed");
  a_local_addr: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && any_hit |=> hit.local_addr
      == $past(loc_base_r[r_pg][hb]) + $past(req.addr[31:0] & hmask[31:0]))
    else $error("local address wrong");
  a_legacy_pin: assert property (@(posedge clk) disable iff (!rst_n)
    leg_req && leg_assert && i_func_ok && !irq_ctl_r[i_pg].leg_off
      |=> legacy_int == (4'h1 << $past(irq_ctl_r[i_pg].pin)))
    else $error("wrong legacy pin");
  a_msi_off: assert property (@(posedge clk) disable iff (!rst_n)
    msi_req && irq_ctl_r[i_pg].msi_off |=> !msi_send && irq_drop)
    else $error("msi sent while off");
  a_msi_range: assert property (@(posedge clk) disable iff (!rst_n)
    msi_req && irq.vec >= (11'h1 << irq_ctl_r[i_pg].msi_mmc) |=> !msi_send)
    else $error("msi vector out of range");
  a_msix_range: assert property (@(posedge clk) disable iff (!rst_n)
    msix_req && !msix_ok |=> !msix_send ##1 !msix_send || $past(msix_req))
    else $error("msix vector beyond table");
  a_io_no_pref: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req.io |=> !hit.prefetch) else $error("io hit prefetchable");

endmodule : epbc_core

// File: design/epbc_pkg.sv
// epbc_pkg: constants, register map and carrier types for the endpoint
// bar and interrupt configuration block.
// assumes a 32-bit apb register port and a 10 mhz core clock.
package epbc_pkg;

  // structure of the endpoint
  localparam int NUM_LINKS = 2;
  localparam int NUM_FUNCS = 8;
  localparam int NUM_BARS = 6;
  localparam int NUM_ENTRIES = NUM_LINKS * NUM_FUNCS;

  // legal window exponents: 16 b..2 gb, 4 gb..8 eb, 2 b..256 b
  localparam logic [5:0] SIZE_MEM32_MIN = 6'h04;
  localparam logic [5:0] SIZE_MEM32_MAX = 6'h1f;
  localparam logic [5:0] SIZE_MEM64_MIN = 6'h20;
  localparam logic [5:0] SIZE_MEM64_MAX = 6'h3f;
  localparam logic [5:0] SIZE_IO_MIN = 6'h01;
  localparam logic [5:0] SIZE_IO_MAX = 6'h08;

  // apb address fields
  localparam int ADDR_LINK_BIT = 11;
  localparam int ADDR_FUNC_LSB = 8;
  localparam int ADDR_WORD_LSB = 2;

  // word indices inside one link/function page
  localparam logic [5:0] REG_BAR_CFG = 6'h00;
  localparam logic [5:0] REG_BAR_BASE = 6'h06;
  localparam logic [5:0] REG_LOC_BASE = 6'h0c;
  localparam logic [5:0] REG_IRQ_CTL = 6'h12;
  localparam logic [5:0] REG_MSIX_CTL = 6'h13;
  localparam logic [5:0] REG_MSIX_TBL = 6'h14;
  localparam logic [5:0] REG_MSIX_PBA = 6'h15;
  localparam logic [5:0] REG_MSI_MASK = 6'h16;
  localparam logic [5:0] REG_NUM_FUNC = 6'h17;
  localparam logic [5:0] REG_STATUS = 6'h18;

  // bar_window_config field positions
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_IO_BIT = 1;
  localparam int CFG_B64_BIT = 2;
  localparam int CFG_PF_BIT = 3;
  localparam int CFG_SIZE_LSB = 8;
  localparam int CFG_LEGAL_BIT = 16;

  // interrupt control field positions
  localparam int IRQ_LEG_OFF_BIT = 0;
  localparam int IRQ_PIN_LSB = 1;
  localparam int IRQ_MSI_OFF_BIT = 4;
  localparam int IRQ_MSI_MMC_LSB = 5;
  localparam int IRQ_MSI_MASKCAP_BIT = 8;
  localparam int MSIX_OFF_BIT = 0;
  localparam int MSIX_CNT_LSB = 1;
  localparam int MSIX_TBIR_LSB = 12;
  localparam int MSIX_PBIR_LSB = 16;
  localparam int MSIX_TCFG_LSB = 24;

  // encodings and reset values
  localparam logic [1:0] PIN_INTA = 2'h0;
  localparam logic [1:0] PIN_INTB = 2'h1;
  localparam logic [1:0] PIN_INTC = 2'h2;
  localparam logic [1:0] PIN_INTD = 2'h3;
  localparam logic [2:0] MSI_MMC_MAX = 3'h5;
  localparam logic [2:0] BIR_MAX = 3'h5;
  localparam logic [7:0] CFG_BAR_BLOCK = 8'h10;
  localparam logic [3:0] NUM_FUNC_RST = 4'h1;
  localparam logic [3:0] NUM_FUNC_MAX = 4'h8;
  localparam int OFFSET_SHIFT = 3;
  localparam int MSIX_ENTRY_SHIFT = 4;

  typedef enum logic [1:0] {EPBC_RGN_NONE, EPBC_RGN_TABLE, EPBC_RGN_PBA} epbc_region_e;

  typedef struct packed {
    logic [5:0] size_log2;
    logic prefetch;
    logic is64;
    logic io;
    logic en;
  } epbc_bar_cfg_s;

  typedef struct packed {
    logic [63:0] addr;
    logic io;
    logic link;
    logic [2:0] func;
  } epbc_req_s;

  typedef struct packed {
    logic miss;
    logic [2:0] bar;
    logic [31:0] local_addr;
    logic prefetch;
    epbc_region_e region;
  } epbc_hit_s;

  typedef struct packed {
    logic link;
    logic [2:0] func;
    logic [10:0] vec;
  } epbc_irq_s;

  typedef struct packed {
    logic msi_maskcap;
    logic [2:0] msi_mmc;
    logic msi_off;
    logic [1:0] pin;
    logic leg_off;
    logic msix_off;
    logic [10:0] msix_cnt_m1;
    logic [2:0] tbl_bir;
    logic [2:0] pba_bir;
  } epbc_irq_ctl_s;

endpackage : epbc_pkg

// File: tb/endpoint_bar_interrupt_config_tb.sv
// bench: bar decode, interrupt gating and apb access of epbc_core.
// assumes an apb slave that answers with pready, and the host model beside it.
`timescale 1ns/1ps
module endpoint_bar_interrupt_config_tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic req_valid, hit_valid, leg_req, leg_assert, msi_req, msix_req;
  logic msi_send, msix_send, irq_drop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] legacy_int;
  epbc_pkg::epbc_req_s req;
  epbc_pkg::epbc_hit_s hit;
  epbc_pkg::epbc_irq_s irq;
  int mismatches, n_tests;

  // design and far side
  epbc_core DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req),
    .hit_valid(hit_valid), .hit(hit), .leg_req(leg_req), .leg_assert(leg_assert),
    .msi_req(msi_req), .msix_req(msix_req), .irq(irq), .legacy_int(legacy_int),
    .msi_send(msi_send), .msix_send(msix_send), .irq_drop(irq_drop));
  epbc_host_model host (.clk(clk), .req_valid(req_valid), .req(req));

  // 10 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // one apb transfer on link 0 function 0; answer kept in rd and er
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {4'h0, a, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // answer and read data are taken at the edge that sees pready
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // request through the host, then judge the decode one cycle later
  task automatic req_go(input logic [63:0] a, input logic io, input logic [2:0] f,
    input logic m, input logic [2:0] b, input logic pf, input logic [31:0] loc);
    host.send(a, io, f);
    @(negedge clk);
    chk("hit", {1'b1, m, b, pf, loc}, m ? {hit_valid, hit.miss, 36'h0} :
      {hit_valid, hit.miss, hit.bar, hit.prefetch, io ? loc : hit.local_addr});
  endtask : req_go

  // interrupt request k = {msix, msi, legacy}; e = {legacy_int, sends, drop}
  task automatic irq_go(input logic [2:0] k, input logic [10:0] v, input logic [6:0] e);
    @(posedge clk);
    {msix_req, msi_req, leg_req} <= k;
    irq <= '{link: 1'b0, func: 3'h0, vec: v};
    @(posedge clk);
    {msix_req, msi_req, leg_req} <= 3'h0;
    irq <= ~irq;
    @(negedge clk);
    chk("irq out", e, {legacy_int, msi_send, msix_send, irq_drop});
  endtask : irq_go

  task automatic t_reset();
    apb(1'b0, epbc_pkg::REG_NUM_FUNC, 32'h0);
    chk("num func", 32'h1, rd);
    apb(1'b0, 6'h19, 32'h0);
    chk("unmapped", 33'h1_0000_0000, {er, rd});
  endtask : t_reset

  task automatic t_bars();
    logic [5:0] wa[11] = '{6'h00, 6'h06, 6'h0c, 6'h01, 6'h07, 6'h02, 6'h08,
      6'h03, 6'h09, 6'h04, 6'h0b};
    logic [31:0] wd[11] = '{32'h0c09, 32'h8000_0000, 32'h0010_0000, 32'h0301,
      32'h9000_0000, 32'h0c00, 32'ha000_0000, 32'h080b, 32'h1000, 32'h2005, 32'h1};
    foreach (wa[i]) apb(1'b1, wa[i], wd[i]);
    apb(1'b0, 6'h03, 32'h0);
    chk("io cfg", 32'h0001_0803, rd);
    apb(1'b0, 6'h01, 32'h0);
    chk("bad size cfg", 32'h0301, rd);
    req_go(64'h8000_0123, 1'b0, 3'h0, 1'b0, 3'h0, 1'b1, 32'h0010_0123);
    req_go(64'h8000_1000, 1'b0, 3'h0, 1'b1, 3'h0, 1'b0, 32'h0);
    req_go(64'h9000_0004, 1'b0, 3'h0, 1'b1, 3'h0, 1'b0, 32'h0);
    req_go(64'ha000_0004, 1'b0, 3'h0, 1'b1, 3'h0, 1'b0, 32'h0);
    req_go(64'h1010, 1'b1, 3'h0, 1'b0, 3'h3, 1'b0, 32'h0);
    req_go(64'h1010, 1'b0, 3'h0, 1'b1, 3'h0, 1'b0, 32'h0);
    req_go(64'h1_0000_0040, 1'b0, 3'h0, 1'b0, 3'h4, 1'b0, 32'h40);
    req_go(64'h8000_0000, 1'b0, 3'h1, 1'b1, 3'h0, 1'b0, 32'h0);
  endtask : t_bars

  task automatic t_msi();
    apb(1'b1, epbc_pkg::REG_IRQ_CTL, 32'h40);
    irq_go(3'b010, 11'h3, 7'h04);
    irq_go(3'b010, 11'h4, 7'h01);
    apb(1'b1, epbc_pkg::REG_MSI_MASK, 32'h8);
    apb(1'b1, epbc_pkg::REG_IRQ_CTL, 32'h140);
    irq_go(3'b010, 11'h3, 7'h01);
    irq_go(3'b010, 11'h2, 7'h04);
    apb(1'b1, epbc_pkg::REG_IRQ_CTL, 32'h10);
    irq_go(3'b010, 11'h0, 7'h01);
  endtask : t_msi

  task automatic t_msix();
    apb(1'b1, epbc_pkg::REG_MSIX_CTL, 32'h0001_2006);
    irq_go(3'b100, 11'h3, 7'h02);
    irq_go(3'b100, 11'h4, 7'h01);
    apb(1'b0, epbc_pkg::REG_MSIX_CTL, 32'h0);
    chk("msix ctl", 32'h1801_2006, rd);
    apb(1'b1, epbc_pkg::REG_MSIX_CTL, 32'h0001_2007);
    irq_go(3'b100, 11'h0, 7'h01);
    apb(1'b1, epbc_pkg::REG_MSIX_TBL, 32'h6007);
    apb(1'b0, epbc_pkg::REG_MSIX_TBL, 32'h0);
    chk("table offset", 32'h6000, rd);
    apb(1'b1, epbc_pkg::REG_MSIX_PBA, 32'h700f);
    apb(1'b0, epbc_pkg::REG_MSIX_PBA, 32'h0);
    chk("pending offset", 32'h7008, rd);
  endtask : t_msix

  // msix table and pending array placed inside bar 0, then the claim count
  task automatic t_region();
    logic [63:0] ad[3] = '{64'h8000_0130, 64'h8000_0204, 64'h8000_0140};
    epbc_pkg::epbc_region_e rg[3] = '{epbc_pkg::EPBC_RGN_TABLE, epbc_pkg::EPBC_RGN_PBA,
      epbc_pkg::EPBC_RGN_NONE};
    apb(1'b1, epbc_pkg::REG_MSIX_CTL, 32'h6);
    apb(1'b1, epbc_pkg::REG_MSIX_TBL, 32'h100);
    apb(1'b1, epbc_pkg::REG_MSIX_PBA, 32'h200);
    foreach (ad[i])
    begin
      host.send(ad[i], 1'b0, 3'h0);
      @(negedge clk);
      chk("region", rg[i], hit.region);
    end
    apb(1'b0, epbc_pkg::REG_STATUS, 32'h0);
    chk("hit count", 32'h6, rd);
  endtask : t_region

  task automatic t_legacy();
    for (int p = 0; p < 4; p++)
    begin
      apb(1'b1, epbc_pkg::REG_IRQ_CTL, 32'(p) << 1);
      irq_go(3'b001, 11'h0, {4'h1 << p, 3'h0});
    end
    apb(1'b1, epbc_pkg::REG_IRQ_CTL, 32'h1);
    irq_go(3'b001, 11'h0, 7'h00);
    apb(1'b1, epbc_pkg::REG_IRQ_CTL, 32'h4);
    irq_go(3'b001, 11'h0, 7'h20);
    @(posedge clk) leg_assert <= 1'b0;
    irq_go(3'b001, 11'h0, 7'h00);
  endtask : t_legacy

  task automatic close_out();
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // main sequence after a 5-cycle reset
  initial
  begin
    mismatches = 0;
    n_tests = 0;
    rst_n = 1'b0;
    {psel, penable, pwrite, leg_req, msi_req, msix_req} = '0;
    leg_assert = 1'b1;
    paddr = '0;
    pwdata = '0;
    irq = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_bars();
    t_msi();
    t_msix();
    t_region();
    t_legacy();
    close_out();
  end

  // watchdog against a hung handshake
  initial
  begin
    repeat (4000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule : endpoint_bar_interrupt_config_tb

// File: tb/epbc_host_model.sv
// epbc_host_model: root complex side that issues requests into the decoder.
// assumes the bench clock; one request per call, one cycle long.
`timescale 1ns/1ps
module epbc_host_model (
  // clock
  input wire logic clk,
  // request into the decoder
  output logic req_valid,
  output epbc_pkg::epbc_req_s req
);
  // idle at time zero
  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end
  // one-cycle pulse; the payload is scrambled once it is released
  task automatic send(input logic [63:0] a, input logic io, input logic [2:0] f);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{addr: a, io: io, link: 1'b0, func: f};
    @(posedge clk);
    req_valid <= 1'b0;
    req <= ~req;
  endtask : send
endmodule : epbc_host_model
